/* verilog/mcad_pkg.sv */
// Shared constants for the microcore ALU operand decoder.
package mcad_pkg;
  localparam int DATA_W = 16;
  localparam int CODE_W = 5;
  localparam int ALU_W = 3;
  localparam int LIT_W = 4;
  localparam int JUMP_W = 10;
  localparam int NUM_REGS = 32;
  // Instruction opcode fields.
  localparam logic [5:0] OPC_SUM = 6'h0a;
  localparam logic [5:0] OPC_SUM_LIT = 6'h06;
  localparam logic [12:0] OPC_MASK = 13'h05d9;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int MASK_LO = 3;
  localparam int DST_HI = 9;
  localparam int DST_LO = 7;
  localparam int ZERO_BIT = 6;
  localparam int SRC2_HI = 5;
  localparam int SRC2_LO = 3;
  localparam int LIT_HI = 6;
  localparam int LIT_LO = 3;
  localparam int SRC1_HI = 2;
  // Core operand codes with a fixed meaning.
  localparam logic [4:0] CODE_IMM = 5'h05;
  localparam logic [4:0] CODE_COND = 5'h08;
  localparam logic [4:0] CODE_AUX = 5'h09;
  localparam logic [4:0] CODE_JUMP_A = 5'h0a;
  localparam logic [4:0] CODE_JUMP_B = 5'h0b;
  localparam logic [4:0] CODE_COUNT = 5'h0c;
  localparam logic [4:0] CODE_LIMIT = 5'h10;
  localparam logic [4:0] CODE_FLAG = 5'h14;
  localparam logic [4:0] CODE_CTRL = 5'h15;
  localparam logic [4:0] CODE_STATUS = 5'h16;
  localparam logic [4:0] CODE_SERIAL = 5'h17;
  localparam logic [4:0] CODE_LEVEL = 5'h18;
  localparam logic [4:0] CODE_INDEX = 5'h1d;
  localparam logic [4:0] CODE_EVENT = 5'h1e;
  localparam logic [4:0] CODE_PEER = 5'h1f;
  // Condition register bit positions.
  localparam int CB_CARRY = 0;
  localparam int CB_ZERO = 1;
  localparam int CB_NEG = 2;
  localparam int CB_UBOR = 3;
  localparam int CB_UOVR = 4;
  localparam int CB_SBEL = 5;
  localparam int CB_SOVR = 6;
  localparam int CB_MZERO = 7;
  localparam int CB_MONES = 8;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  typedef enum logic [3:0] {
    CLS_ALU, CLS_COND, CLS_AUX, CLS_JUMP, CLS_COUNT, CLS_LIMIT, CLS_FLAG,
    CLS_CTRL, CLS_STATUS, CLS_SERIAL, CLS_LEVEL, CLS_INDEX, CLS_EVENT, CLS_PEER
  } mcad_class_e;
endpackage

/* verilog/mcad_core_decode.sv */
// Classifies a 5-bit core operand code into its register group.
`timescale 1ns/100ps
module mcad_core_decode (
  input wire logic [4:0] code,             // Core operand code.
  output mcad_pkg::mcad_class_e reg_class  // Register group addressed.
);
  // Groups stand in ascending code order, so a chain of bounds suffices.
  always_comb
  begin
    if (code < mcad_pkg::CODE_COND)
      reg_class = mcad_pkg::CLS_ALU;
    else if (code == mcad_pkg::CODE_COND)
      reg_class = mcad_pkg::CLS_COND;
    else if (code == mcad_pkg::CODE_AUX)
      reg_class = mcad_pkg::CLS_AUX;
    else if (code < mcad_pkg::CODE_COUNT)
      reg_class = mcad_pkg::CLS_JUMP;
    else if (code < mcad_pkg::CODE_LIMIT)
      reg_class = mcad_pkg::CLS_COUNT;
    else if (code < mcad_pkg::CODE_FLAG)
      reg_class = mcad_pkg::CLS_LIMIT;
    else if (code == mcad_pkg::CODE_FLAG)
      reg_class = mcad_pkg::CLS_FLAG;
    else if (code == mcad_pkg::CODE_CTRL)
      reg_class = mcad_pkg::CLS_CTRL;
    else if (code == mcad_pkg::CODE_STATUS)
      reg_class = mcad_pkg::CLS_STATUS;
    else if (code == mcad_pkg::CODE_SERIAL)
      reg_class = mcad_pkg::CLS_SERIAL;
    else if (code < mcad_pkg::CODE_INDEX)
      reg_class = mcad_pkg::CLS_LEVEL;
    else if (code == mcad_pkg::CODE_INDEX)
      reg_class = mcad_pkg::CLS_INDEX;
    else if (code == mcad_pkg::CODE_EVENT)
      reg_class = mcad_pkg::CLS_EVENT;
    else
      reg_class = mcad_pkg::CLS_PEER;
  end
endmodule

/* verilog/mcad_sum_unit.sv */
// Sixteen-bit adder with its seven arithmetic condition flags.
`timescale 1ns/100ps
module mcad_sum_unit #(
  parameter int W = mcad_pkg::DATA_W
) (
  input wire logic [W-1:0] a,     // First addend.
  input wire logic [W-1:0] b,     // Second addend.
  output logic [W-1:0] sum,       // Truncated sum.
  output logic carry,             // Carry out of the top bit.
  output logic zero,              // Sum is all zero.
  output logic neg,               // Sum top bit set.
  output logic ubor,              // Unsigned underflow.
  output logic uovr,              // Unsigned overflow.
  output logic sbel,              // Signed underflow.
  output logic sovr               // Signed overflow.
);
  logic [W:0] wide;
  // An add can never borrow, so unsigned underflow stays low here.
  always_comb
  begin
    wide = {1'b0, a} + {1'b0, b};
    sum = wide[W-1:0];
    carry = wide[W];
    zero = (wide[W-1:0] == '0);
    neg = wide[W-1];
    ubor = 1'b0;
    uovr = wide[W];
    sbel = a[W-1] & b[W-1] & ~wide[W-1];
    sovr = ~a[W-1] & ~b[W-1] & wide[W-1];
  end
endmodule

/* verilog/mcad_decoder.sv */
// Top of the microcore ALU operand decoder: register file, sum, sum-literal and mask.
// Notes on behaviour
// - Three-bit ALU codes pick general, literal, product registers.
// - Five-bit core codes span all core registers.
// - Codes 11110 event status, 11111 peer channel.
// - Codes 01000 condition, 10101 control, 10110 status.
// - Jump select bit picks target a or b.
// - Sum adds two sources, writes destination, records carry.
// - Sums update seven arithmetic condition bits.
// - Sum word is 001010, dst, 0, src2, src1.
// - Sum-literal adds four-bit literal to source.
// - Sum-literal word is 000110, dst, literal, src.
// - Mask ANDs register with literal register in place.
// - Mask sets all-zero and all-one bits.
// - Mask word is 0010111011001 then register.
// - Every core register reachable for read and write.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module mcad_decoder #(
  parameter int W = mcad_pkg::DATA_W,
  parameter int JW = mcad_pkg::JUMP_W
) (
  input wire logic mclk,               // Core clock.
  input wire logic arst_n,             // Asynchronous reset, active low.
  input wire logic instr_valid,        // Instruction word presented this cycle.
  input wire logic [15:0] instr_word,  // Instruction word from the sequencer.
  input wire logic [4:0] reg_addr,     // Core operand code of the register port.
  input wire logic [W-1:0] reg_wdata,  // Register port write data.
  input wire logic reg_wr,             // Register port write strobe.
  input wire logic reg_rd,             // Register port read strobe.
  output logic [W-1:0] reg_rdata_q,    // Read data, one cycle after the strobe.
  input wire logic jump_sel,           // Jump operand bit.
  output logic [JW-1:0] jump_target_q, // Selected jump target.
  output logic [W-1:0] core_ctrl_q,    // Core control register contents.
  output logic exec_done_q,            // Pulse: a recognised instruction completed.
  output logic exec_bad_q,             // Pulse: word was not one of ours.
  output logic peer_wr_q,              // Pulse: peer channel register written.
  output logic event_rd_q              // Pulse: event status register read.
);
  logic [W-1:0] file_q [0:mcad_pkg::NUM_REGS-1];
  logic is_sum;
  logic is_lit;
  logic is_mask;
  logic do_arith;
  logic [4:0] dst_code;
  logic [4:0] src1_code;
  logic [4:0] src2_code;
  logic [W-1:0] opnd_a;
  logic [W-1:0] opnd_b;
  logic [W-1:0] sum;
  logic carry;
  logic zero;
  logic neg;
  logic ubor;
  logic uovr;
  logic sbel;
  logic sovr;
  logic [W-1:0] mask_res;
  logic [W-1:0] cond_d;
  mcad_pkg::mcad_class_e bus_class;

  // An ALU operand field is the low corner of the core code space.
  function automatic logic [4:0] alu_code(input logic [2:0] f);
    alu_code = {2'b00, f};
  endfunction

  // Opcode match for the three instructions handled here.
  always_comb
  begin
    is_sum = instr_valid && instr_word[mcad_pkg::OPC_HI:mcad_pkg::OPC_LO] == mcad_pkg::OPC_SUM
             && !instr_word[mcad_pkg::ZERO_BIT];
    is_lit = instr_valid
             && instr_word[mcad_pkg::OPC_HI:mcad_pkg::OPC_LO] == mcad_pkg::OPC_SUM_LIT;
    is_mask = instr_valid && instr_word[mcad_pkg::OPC_HI:mcad_pkg::MASK_LO] == mcad_pkg::OPC_MASK;
  end

  // Operand fields; the mask writes back into its own source.
  always_comb
  begin
    src1_code = alu_code(instr_word[mcad_pkg::SRC1_HI:0]);
    src2_code = alu_code(instr_word[mcad_pkg::SRC2_HI:mcad_pkg::SRC2_LO]);
    dst_code = is_mask ? src1_code : alu_code(instr_word[mcad_pkg::DST_HI:mcad_pkg::DST_LO]);
    opnd_a = file_q[src1_code];
    if (is_lit)
      opnd_b = {{(W - mcad_pkg::LIT_W){1'b0}}, instr_word[mcad_pkg::LIT_HI:mcad_pkg::LIT_LO]};
    else
      opnd_b = file_q[src2_code];
    mask_res = opnd_a & file_q[mcad_pkg::CODE_IMM];
    do_arith = is_sum || is_lit || is_mask;
  end

  mcad_sum_unit #(
    .W(W)
  ) u_sum (
    .a(opnd_a),
    .b(opnd_b),
    .sum(sum),
    .carry(carry),
    .zero(zero),
    .neg(neg),
    .ubor(ubor),
    .uovr(uovr),
    .sbel(sbel),
    .sovr(sovr)
  );

  mcad_core_decode u_dec (
    .code(reg_addr),
    .reg_class(bus_class)
  );

  // New condition word: each instruction touches only its own bits.
  always_comb
  begin
    cond_d = file_q[mcad_pkg::CODE_COND];
    if (is_mask)
    begin
      cond_d[mcad_pkg::CB_MZERO] = (mask_res == '0);
      cond_d[mcad_pkg::CB_MONES] = (mask_res == '1);
    end
    else
    begin
      cond_d[mcad_pkg::CB_CARRY] = carry;
      cond_d[mcad_pkg::CB_ZERO] = zero;
      cond_d[mcad_pkg::CB_NEG] = neg;
      cond_d[mcad_pkg::CB_UBOR] = ubor;
      cond_d[mcad_pkg::CB_UOVR] = uovr;
      cond_d[mcad_pkg::CB_SBEL] = sbel;
      cond_d[mcad_pkg::CB_SOVR] = sovr;
    end
  end

  // Register file. The instruction write comes last so that it wins when the
  // port hits the same register in the same cycle; the sequencer owns the core.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < mcad_pkg::NUM_REGS; i++)
        file_q[i] <= mcad_pkg::RESET_VAL;
    end
    else
    begin
      if (reg_wr)
        file_q[reg_addr] <= reg_wdata;
      if (do_arith)
      begin
        file_q[dst_code] <= is_mask ? mask_res : sum;
        file_q[mcad_pkg::CODE_COND] <= cond_d;
      end
    end
  end

  // Read data stand only in the cycle after the strobe, otherwise zero.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_q <= '0;
    else if (reg_rd)
      reg_rdata_q <= file_q[reg_addr];
    else
      reg_rdata_q <= '0;
  end

  // Jump target follows the jump operand bit; only the low bits form an address.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      jump_target_q <= '0;
    else
      jump_target_q <= file_q[jump_sel ? mcad_pkg::CODE_JUMP_B : mcad_pkg::CODE_JUMP_A][JW-1:0];
  end

  // Control register is mirrored out for the rest of the core.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      core_ctrl_q <= '0;
    else
      core_ctrl_q <= file_q[mcad_pkg::CODE_CTRL];
  end

  // Completion and rejection pulses, one cycle after the word.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_done_q <= 1'b0;
      exec_bad_q <= 1'b0;
    end
    else
    begin
      exec_done_q <= do_arith;
      exec_bad_q <= instr_valid && !do_arith;
    end
  end

  // Peer and event accesses are flagged so neighbouring logic can react.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      peer_wr_q <= 1'b0;
      event_rd_q <= 1'b0;
    end
    else
    begin
      peer_wr_q <= reg_wr && bus_class == mcad_pkg::CLS_PEER;
      event_rd_q <= reg_rd && bus_class == mcad_pkg::CLS_EVENT;
    end
  end

  // Reference results computed apart from the datapath, for the checks below.
  logic [W:0] chk_sum;
  logic [W:0] chk_lit;
  logic [W-1:0] chk_mask;
  assign chk_sum = {1'b0, file_q[src1_code]} + {1'b0, file_q[src2_code]};
  assign chk_lit = {1'b0, file_q[src1_code]} + {{(W + 1 - mcad_pkg::LIT_W){1'b0}}, instr_word[6:3]};
  assign chk_mask = file_q[src1_code] & file_q[mcad_pkg::CODE_IMM];
  // Independent opcode match, so the rejection checks do not lean on the datapath decode.
  logic chk_known;
  assign chk_known = (instr_word[15:10] == 6'h0a && !instr_word[6]) || instr_word[15:10] == 6'h06
                     || instr_word[15:3] == 13'h05d9;

  // All checks run on the core clock and rest while reset is held.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_sum_issued;
    instr_valid && instr_word[15:10] == 6'h0a && !instr_word[6];
  endsequence
  sequence s_lit_issued;
    instr_valid && instr_word[15:10] == 6'h06;
  endsequence
  sequence s_mask_issued;
    instr_valid && instr_word[15:3] == 13'h05d9;
  endsequence

  // The sum lands in the destination code one edge after the word.
  a_sum_result: assert property (s_sum_issued |=>
    file_q[$past(instr_word[9:7])] == $past(chk_sum[15:0]))
    else $error("sum result not written to destination");

  // Carry and unsigned overflow are the same bit for an add.
  a_sum_carry: assert property (s_sum_issued |=>
    file_q[8][0] == $past(chk_sum[16]) && file_q[8][4] == file_q[8][0])
    else $error("sum carry not recorded");

  // Zero and sign follow the stored result; an add never borrows.
  a_sum_flags: assert property (s_sum_issued |=>
    file_q[8][1] == (file_q[$past(instr_word[9:7])] == 16'h0000)
    && file_q[8][2] == file_q[$past(instr_word[9:7])][15] && !file_q[8][3])
    else $error("sum zero or sign bit wrong");

  // The literal is zero-extended, so only the low nibble can be added.
  a_lit_result: assert property (s_lit_issued |=>
    file_q[$past(instr_word[9:7])] == $past(chk_lit[15:0]) && file_q[8][0] == $past(chk_lit[16]))
    else $error("literal sum wrong");

  // The mask overwrites its own source register.
  a_mask_result: assert property (s_mask_issued |=>
    file_q[$past(instr_word[2:0])] == $past(chk_mask))
    else $error("mask result not written back");

  // All-zero and all-one bits come from the masked value itself.
  a_mask_flags: assert property (s_mask_issued |=>
    file_q[8][7] == ($past(chk_mask) == 16'h0000) && file_q[8][8] == ($past(chk_mask) == 16'hffff))
    else $error("mask condition bits wrong");

  // A mask leaves the arithmetic bits from the last sum untouched.
  a_mask_keeps_sum: assert property (s_mask_issued |=>
    file_q[8][6:0] == $past(file_q[8][6:0]))
    else $error("mask disturbed arithmetic bits");

  // Every recognised word completes in one clock and says so.
  a_done_pulse: assert property ((s_sum_issued or s_lit_issued or s_mask_issued) |=>
    exec_done_q && !exec_bad_q)
    else $error("completion pulse missing");

  // Read data stand for one cycle only; a back-to-back read keeps the next value up.
  a_read_window: assert property (reg_rd |=> reg_rdata_q == $past(file_q[reg_addr])
    ##1 ($past(reg_rd) || reg_rdata_q == 16'h0000))
    else $error("read data outside its cycle");

  // The jump bit picks between the two jump targets with one cycle of latency.
  a_jump_pick: assert property (##1 jump_target_q == $past(file_q[jump_sel ? 11 : 10][9:0]))
    else $error("jump target not selected by operand bit");

  // A write to the peer code must be flagged to the neighbouring channel.
  a_peer_code: assert property (reg_wr && reg_addr == 5'h1f |=> peer_wr_q)
    else $error("peer register write not flagged");

  // The control code feeds the mirrored control output two edges later.
  a_ctrl_code: assert property (reg_wr && reg_addr == 5'h15 && !instr_valid |-> ##2
    core_ctrl_q == $past(reg_wdata, 2))
    else $error("control register not at its code");

  // Any word outside the three kinds only raises the rejection pulse.
  a_bad_pulse: assert property (instr_valid && !chk_known |=> exec_bad_q && !exec_done_q)
    else $error("unknown word not rejected");

  // A rejected word must leave the condition word alone; port writes stay out of the antecedent.
  a_bad_keeps_cond: assert property (instr_valid && !chk_known && !reg_wr |=>
    file_q[8] == $past(file_q[8]))
    else $error("unknown word changed the condition word");

  // With no word offered, neither pulse may appear.
  a_idle_quiet: assert property (!instr_valid |=> !exec_done_q && !exec_bad_q)
    else $error("pulse without an instruction");

  // The event and peer pulses answer their own code and nothing else.
  a_event_code: assert property (reg_rd && reg_addr == 5'h1e |=> event_rd_q)
    else $error("event register read not flagged");
  a_event_only: assert property (!(reg_rd && reg_addr == 5'h1e) |=> !event_rd_q)
    else $error("event pulse without its read");
  a_peer_only: assert property (!(reg_wr && reg_addr == 5'h1f) |=> !peer_wr_q)
    else $error("peer pulse without its write");

  // A port write lands at its own code whenever no instruction competes for the file.
  a_port_write: assert property (reg_wr && !(instr_valid && chk_known) |=>
    file_q[$past(reg_addr)] == $past(reg_wdata))
    else $error("port write did not reach its code");

  // With no strobe the read data fall back to zero, so stale data never look fresh.
  a_read_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data without a strobe");

  // The literal sum sets the same zero, sign and overflow bits as the plain sum.
  a_lit_flags: assert property (s_lit_issued |=>
    file_q[8][1] == (file_q[$past(instr_word[9:7])] == 16'h0000)
    && file_q[8][2] == file_q[$past(instr_word[9:7])][15]
    && !file_q[8][3] && file_q[8][4] == file_q[8][0])
    else $error("literal sum condition bits wrong");

  // Signed limits depend on the operand signs as well as the result sign.
  a_sum_signed: assert property (s_sum_issued |=>
    file_q[8][5] == $past(file_q[instr_word[2:0]][15] & file_q[instr_word[5:3]][15] & ~chk_sum[15])
    && file_q[8][6] == $past(~file_q[instr_word[2:0]][15] & ~file_q[instr_word[5:3]][15] & chk_sum[15]))
    else $error("signed limit bits wrong");

  // Each instruction owns its own slice of the condition word and leaves the rest alone.
  a_sum_keeps_mask: assert property ((s_sum_issued or s_lit_issued) |=>
    file_q[8][15:7] == $past(file_q[8][15:7]))
    else $error("sum disturbed mask or upper bits");
  a_mask_keeps_top: assert property (s_mask_issued |=>
    file_q[8][15:9] == $past(file_q[8][15:9]))
    else $error("mask disturbed upper bits");
endmodule

/* sim/mcad_seq_model.sv */
// Program sequencer model that presents one instruction word per request.
`timescale 1ns/100ps
module mcad_seq_model (
  input wire logic mclk,             // Core clock.
  input wire logic arst_n,           // Reset, active low.
  input wire logic send,             // Present send_word in the next cycle.
  input wire logic [15:0] send_word, // Word to present.
  output logic instr_valid,          // Word valid to the decoder.
  output logic [15:0] instr_word     // Word to the decoder.
);
  // Idle cycles show a word that flips every cycle, so a decoder that reads a stale word is caught.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      instr_valid <= 1'b0;
      instr_word <= 16'h5a5a;
    end
    else
    begin
      instr_valid <= send;
      instr_word <= send ? send_word : ~instr_word;
    end
  end
endmodule

/* sim/mcad_decoder_test.sv */
// Self-checking bench for the ALU operand decoder: register port, sums, mask and pulses.
`timescale 1ns/100ps
module mcad_decoder_test;
  logic mclk;
  logic arst_n;
  logic send;
  logic [15:0] send_word;
  logic instr_valid;
  logic [15:0] instr_word;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata_q;
  logic jump_sel;
  logic [9:0] jump_target_q;
  logic [15:0] core_ctrl_q;
  logic exec_done_q;
  logic exec_bad_q;
  logic peer_wr_q;
  logic event_rd_q;
  int errors;
  int compares;
  logic [15:0] mem [32];
  logic [15:0] a_tab [4] = '{16'hffff, 16'h7fff, 16'h8000, 16'h1234};
  logic [15:0] b_tab [4] = '{16'h0001, 16'h0001, 16'h8000, 16'h0f0f};
  logic [15:0] imm_tab [3] = '{16'h0f0f, 16'hffff, 16'h00ff};
  logic [15:0] bad_tab [2] = '{16'h2851, 16'hffff};
  logic [2:0] dst;
  logic [3:0] lit;
  logic [15:0] res;

  mcad_seq_model seq (.mclk(mclk), .arst_n(arst_n), .send(send), .send_word(send_word),
    .instr_valid(instr_valid), .instr_word(instr_word));

  mcad_decoder dut (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .jump_sel(jump_sel), .jump_target_q(jump_target_q), .core_ctrl_q(core_ctrl_q), .exec_done_q(exec_done_q),
    .exec_bad_q(exec_bad_q), .peer_wr_q(peer_wr_q), .event_rd_q(event_rd_q));

  // Free-running core clock at 10 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Comparisons on words and on single flags.
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  // One-cycle port write; the data lines change afterwards so nothing relies on them lingering.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    mem[a] = d;
    #1 chk1(peer_wr_q, a == 5'h1f);
  endtask

  // One-cycle port read; the answer is looked at in the single cycle it stands.
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk16(reg_rdata_q, mem[a]);
    chk1(event_rd_q, a == 5'h1e);
  endtask

  // Hands one word to the sequencer model and checks the completion pulse.
  task automatic exec(input logic [15:0] w, input logic ok);
    @(posedge mclk);
    send <= 1'b1;
    send_word <= w;
    @(posedge mclk);
    send <= 1'b0;
    @(posedge mclk);
    #1 chk1(exec_done_q, ok);
    chk1(exec_bad_q, !ok);
  endtask

  // Expected condition word after an add; bits 7 and up are left as they were.
  function automatic logic [15:0] add_cond(input logic [15:0] a, input logic [15:0] b, input logic [15:0] cur);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return {cur[15:7], ~a[15] & ~b[15] & s[15], a[15] & b[15] & ~s[15], s[16], 1'b0, s[15], s[15:0] == 16'h0000, s[16]};
  endfunction

  task automatic complete_run;
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial
  begin
    #2000000;
    errors++;
    $display("Error at %0t: timeout", $time);
    complete_run;
  end

  // Main sequence.
  initial
  begin
    errors = 0;
    compares = 0;
    send = 1'b0;
    send_word = 16'h0000;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    jump_sel = 1'b0;
    arst_n = 1'b0;
    for (int i = 0; i < 32; i++)
      mem[i] = 16'h0000;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(5'h08);
    // Every core code holds its own pattern, proving no two codes alias.
    for (int i = 0; i < 32; i++)
      wr(i[4:0], {3'h5, i[4:0], ~i[7:0]});
    for (int i = 0; i < 32; i++)
      rd(i[4:0]);
    chk16(core_ctrl_q, mem[21]);
    // The jump bit picks one of the two jump targets.
    for (int j = 0; j < 2; j++)
    begin
      @(posedge mclk);
      jump_sel <= j[0];
      @(posedge mclk);
      #1 chk16({6'h00, jump_target_q}, {6'h00, mem[10 + j][9:0]});
    end
    // Sums into every upper ALU code, then literal sums with carry, sign and zero-extension cases.
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h01, a_tab[k]);
      wr(5'h02, b_tab[k]);
      wr(5'h08, 16'hfe80);
      dst = 3'(k + 4);
      mem[8] = add_cond(mem[1], mem[2], mem[8]);
      mem[dst] = mem[1] + mem[2];
      exec({6'h0a, dst, 1'h0, 3'h2, 3'h1}, 1'b1);
      rd({2'h0, dst});
      rd(5'h08);
      wr(5'h03, a_tab[k]);
      lit = {k[1:0], 2'h3};
      mem[8] = add_cond(mem[3], {12'h000, lit}, mem[8]);
      mem[0] = mem[3] + {12'h000, lit};
      exec({6'h06, 3'h0, lit, 3'h3}, 1'b1);
      rd(5'h00);
      rd(5'h08);
    end
    // Masks giving all zeros, all ones and a mixed result.
    for (int k = 0; k < 3; k++)
    begin
      wr(5'h05, imm_tab[k]);
      dst = 3'(k * 3);
      wr({2'h0, dst}, ~imm_tab[k] ^ {16{k == 1}} ^ {16{k == 2}} & 16'hfff0);
      res = mem[dst] & mem[5];
      mem[dst] = res;
      mem[8] = {mem[8][15:9], res == 16'hffff, res == 16'h0000, mem[8][6:0]};
      exec({13'h05d9, dst}, 1'b1);
      rd({2'h0, dst});
      rd(5'h08);
    end
    // Words outside the three kinds change nothing.
    for (int k = 0; k < 2; k++)
    begin
      exec(bad_tab[k], 1'b0);
      rd(5'h00);
      rd(5'h08);
    end
    complete_run;
  end
endmodule
